/* rtl/pceo_params.svh */
// Offsets, reset values and option field positions for the shared port block
`ifndef PCEO_PARAMS_SVH
`define PCEO_PARAMS_SVH

`define PCEO_ADDR_DATA 12'h000
`define PCEO_ADDR_DIR 12'h004
`define PCEO_ADDR_OPTION 12'h008
`define PCEO_ADDR_FORCE 12'h00C
`define PCEO_ADDR_STATUS 12'h010
`define PCEO_ADDR_PORTD 12'h014

`define PCEO_RST_DATA 4'h0
`define PCEO_RST_DIR 4'h0
`define PCEO_RST_PORTD 4'h0

`define PCEO_OPT_CMP1 0
`define PCEO_OPT_CMP2 1
`define PCEO_OPT_AMP 2
`define PCEO_OPT_BIT_ONE_READ_ZERO_OPTION 3
`define PCEO_OPT_BIT_THREE_READ_ZERO_OPTION 4
`define PCEO_OPT_GAIN 5
`define PCEO_OPT_SEL 6
`define PCEO_OPT_BIDIR 7
`define PCEO_OPT_WAKE_LSB 8
`define PCEO_OPT_FHC_LSB 12
`define PCEO_OPT_FHD_LSB 16

`define PCEO_SLVERR 2'h2
`define PCEO_OKAY 2'h0

`endif

/* rtl/pceo_pkg.sv */
// Types shared by the shared port option read mux
package pceo_pkg;
    typedef enum logic [1:0] {
        PCEO_MODE_PLAIN,
        PCEO_MODE_TWO_CMP,
        PCEO_MODE_CMP_AMP,
        PCEO_MODE_AMP
    } pceo_mode_t;

    typedef enum logic [1:0] {
        PCEO_ROLE_OUTPUT,
        PCEO_ROLE_INPUT,
        PCEO_ROLE_BIDIR
    } pceo_role_t;
endpackage

/* rtl/pceo_read_mux.sv */
// Per-bit read data selection for the shared port
`timescale 1ns/1ns
module pceo_read_mux
    import pceo_pkg::*;
(
    input wire logic [3:0] pinLevel,
    input wire logic cmpOneOut,
    input wire logic cmpTwoOut,
    input wire logic comparatorOneEnable,
    input wire logic comparatorTwoEnable,
    input wire logic amplifierEnable,
    input wire logic bitOneReadZero,
    input wire logic bitThreeReadZero,
    output logic [3:0] readValue,
    output pceo_mode_t mode
);
    always_comb begin
        readValue = pinLevel;
        mode = PCEO_MODE_PLAIN;
        if (amplifierEnable && comparatorOneEnable) begin
            mode = PCEO_MODE_CMP_AMP;
            readValue[3] = 1'b0;
            readValue[2] = 1'b0;
            readValue[1] = bitOneReadZero ? 1'b0 : pinLevel[1];
            readValue[0] = cmpOneOut;
        end else if (amplifierEnable) begin
            mode = PCEO_MODE_AMP;
        end else begin
            if (comparatorTwoEnable) begin
                mode = PCEO_MODE_TWO_CMP;
                readValue[3] = bitThreeReadZero ? 1'b0 : pinLevel[3];
                readValue[2] = cmpTwoOut;
            end
            if (comparatorOneEnable) begin
                mode = PCEO_MODE_TWO_CMP;
                readValue[1] = bitOneReadZero ? 1'b0 : pinLevel[1];
                readValue[0] = cmpOneOut;
            end
        end
    end
endmodule // pceo_read_mux

/* rtl/pceo_port.sv */
// Option-configured shared four-bit port with AXI4-Lite register access
// Functional notes
// - All analog options off gives plain port
// - Comparator two: bit3 pin, bit2 comparator
// - Bit-three zero option forces bit3 zero
// - Combined mode: bits3,2 zero, bit0 comparator
// - Bit-one zero option forces bit1 zero
// - Per-pin wake enable gates halt wake
// - Force-high options drive outputs high
// - Select output-only, input-only or bidirectional role
// - Direction bit one means output
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "pceo_params.svh"
module pceo_port
    import pceo_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [31:0] optionStrap,
    input wire logic [3:0] sharedPinIn,
    output logic [3:0] sharedPinOut,
    output logic [3:0] sharedPinOe,
    output logic [3:0] portDOut,
    input wire logic cmpOneOut,
    input wire logic cmpTwoOut,
    input wire logic halted,
    output logic wakeRequest,
    output logic gainAllowed,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [31:0] option;
    logic optionLoaded;
    logic [3:0] shared_port_data_reg;
    logic [3:0] shared_port_direction_reg;
    logic [3:0] portDData;
    logic [3:0] pinPrev;
    logic [3:0] readValue;
    pceo_mode_t mode;
    pceo_role_t role;
    logic [11:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic wHeld;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic wStrbLow;
    logic strbHeld;

    function automatic logic regHit(input logic [11:0] addr);
        regHit = (addr == `PCEO_ADDR_DATA) || (addr == `PCEO_ADDR_DIR) ||
                 (addr == `PCEO_ADDR_PORTD);
    endfunction

    function automatic logic anyHit(input logic [11:0] addr);
        anyHit = regHit(addr) || (addr == `PCEO_ADDR_OPTION) ||
                 (addr == `PCEO_ADDR_FORCE) || (addr == `PCEO_ADDR_STATUS);
    endfunction

    // Options are captured once at the first edge after release, then frozen
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            option <= 32'h0;
            optionLoaded <= 1'b0;
        end else if (!optionLoaded) begin
            option <= optionStrap;
            optionLoaded <= 1'b1;
        end
    end

    always_comb begin
        if (option[`PCEO_OPT_BIDIR]) begin
            role = PCEO_ROLE_BIDIR;
        end else if (option[`PCEO_OPT_SEL]) begin
            role = PCEO_ROLE_INPUT;
        end else begin
            role = PCEO_ROLE_OUTPUT;
        end
    end

    pceo_read_mux u_mux (
        .pinLevel(sharedPinIn),
        .cmpOneOut(cmpOneOut),
        .cmpTwoOut(cmpTwoOut),
        .comparatorOneEnable(option[`PCEO_OPT_CMP1]),
        .comparatorTwoEnable(option[`PCEO_OPT_CMP2]),
        .amplifierEnable(option[`PCEO_OPT_AMP]),
        .bitOneReadZero(option[`PCEO_OPT_BIT_ONE_READ_ZERO_OPTION]),
        .bitThreeReadZero(option[`PCEO_OPT_BIT_THREE_READ_ZERO_OPTION]),
        .readValue(readValue),
        .mode(mode)
    );

    // Gain path only offered when the amplifier is off
    assign gainAllowed = option[`PCEO_OPT_GAIN] && !option[`PCEO_OPT_AMP];

    // Pin drivers; force-high overrides written data on output bits
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sharedPinOut <= 4'h0;
            sharedPinOe <= 4'h0;
            portDOut <= 4'h0;
        end else begin
            sharedPinOut <= shared_port_data_reg | option[`PCEO_OPT_FHC_LSB +: 4];
            portDOut <= portDData | option[`PCEO_OPT_FHD_LSB +: 4];
            case (role)
                PCEO_ROLE_BIDIR: sharedPinOe <= shared_port_direction_reg;
                PCEO_ROLE_INPUT: sharedPinOe <= 4'h0;
                PCEO_ROLE_OUTPUT: sharedPinOe <= 4'hF;
                default: sharedPinOe <= 4'h0;
            endcase
        end
    end

    // Rising edge on an enabled input pin during halt requests wake
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pinPrev <= 4'h0;
            wakeRequest <= 1'b0;
        end else begin
            pinPrev <= sharedPinIn;
            wakeRequest <= halted && |(sharedPinIn & ~pinPrev & ~sharedPinOe &
                           option[`PCEO_OPT_WAKE_LSB +: 4]);
        end
    end

    // AXI write channel: address and data accepted in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 12'h000;
            wData <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCEO_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
            end
            if (awHeld && wHeld) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= regHit(awAddr) ? `PCEO_OKAY : `PCEO_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            shared_port_data_reg <= `PCEO_RST_DATA;
            shared_port_direction_reg <= `PCEO_RST_DIR;
            portDData <= `PCEO_RST_PORTD;
        end else if (awHeld && wHeld && wStrbLow) begin
            case (awAddr)
                `PCEO_ADDR_DATA: shared_port_data_reg <= wData[3:0];
                `PCEO_ADDR_DIR: shared_port_direction_reg <= wData[3:0];
                `PCEO_ADDR_PORTD: portDData <= wData[3:0];
                default: ;
            endcase
        end
    end

    assign wStrbLow = strbHeld;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            strbHeld <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            strbHeld <= s_axi_wstrb[0];
        end
    end

    // Read mux: data register returns the option-selected view, or the written data when the role is output-only
    always_comb begin
        next_rdata = 32'h0;
        next_rresp = `PCEO_OKAY;
        case (s_axi_araddr)
            `PCEO_ADDR_DATA: begin
                if (role == PCEO_ROLE_OUTPUT) begin
                    next_rdata[3:0] = shared_port_data_reg;
                end else begin
                    next_rdata[3:0] = readValue;
                end
            end
            `PCEO_ADDR_DIR: next_rdata[3:0] = shared_port_direction_reg;
            `PCEO_ADDR_OPTION: next_rdata = option;
            `PCEO_ADDR_FORCE: next_rdata[3:0] = option[`PCEO_OPT_FHC_LSB +: 4];
            `PCEO_ADDR_STATUS: next_rdata[5:0] = {gainAllowed, wakeRequest, role, mode};
            `PCEO_ADDR_PORTD: next_rdata[3:0] = portDData;
            default: next_rresp = `PCEO_SLVERR;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PCEO_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= anyHit(s_axi_araddr) ? `PCEO_OKAY : next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // pceo_port

/* testbench/pceo_port_checker.sv */
// Checker for read selection, pin roles, forcing and wake of the shared port
`timescale 1ns/1ns
module pceo_port_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [31:0] optionStrap,
    input wire logic [3:0] sharedPinIn,
    input wire logic [3:0] sharedPinOut,
    input wire logic [3:0] sharedPinOe,
    input wire logic [3:0] portDOut,
    input wire logic cmpOneOut,
    input wire logic cmpTwoOut,
    input wire logic halted,
    input wire logic wakeRequest,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid
);
    logic [1:0] age;
    logic rvSeen;
    logic live;
    logic hit;
    logic [31:0] o;
    assign o = optionStrap;
    assign live = age == 2'h3;
    // First answer cycle of a data read while the port is not output-only
    assign hit = live && s_axi_rvalid && !rvSeen && s_axi_araddr == 12'h000 && (o[6] || o[7]);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            age <= 2'h0;
            rvSeen <= 1'b0;
        end else begin
            age <= live ? age : age + 2'h1;
            rvSeen <= s_axi_rvalid;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_plain; hit && o[2:0] == 3'h0 |-> s_axi_rdata[3:0] == sharedPinIn; endproperty
    a_plain: assert property (p_plain) else $error("plain read");
    // Comparator two only substitutes while the amplifier is off
    property p_cmp2;
        hit && o[1] && !o[2] && !o[4] |-> s_axi_rdata[3:2] == {sharedPinIn[3], cmpTwoOut};
    endproperty
    a_cmp2: assert property (p_cmp2) else $error("comparator two read");
    property p_b3z;
        hit && o[1] && !o[2] && o[4] |-> s_axi_rdata[3:2] == {1'b0, cmpTwoOut};
    endproperty
    a_b3z: assert property (p_b3z) else $error("bit three zero");
    property p_comb;
        hit && o[0] && o[2] && !o[3] |-> s_axi_rdata[3:0] == {2'h0, sharedPinIn[1], cmpOneOut};
    endproperty
    a_comb: assert property (p_comb) else $error("combined read");
    property p_b1z;
        hit && o[0] && o[2] && o[3] |-> s_axi_rdata[3:0] == {3'h0, cmpOneOut};
    endproperty
    a_b1z: assert property (p_b1z) else $error("bit one zero");
    property p_force;
        live |-> (sharedPinOut & o[15:12]) == o[15:12] && (portDOut & o[19:16]) == o[19:16];
    endproperty
    a_force: assert property (p_force) else $error("force high");
    property p_role; live && !o[7] |-> sharedPinOe == {4{!o[6]}}; endproperty
    a_role: assert property (p_role) else $error("pin role");
    property p_wake; $rose(wakeRequest) |-> $past(halted) && o[11:8] != 4'h0; endproperty
    a_wake: assert property (p_wake) else $error("wake");
endmodule // pceo_port_checker

bind pceo_port pceo_port_checker chk (.core_clk, .resetn, .optionStrap, .sharedPinIn,
    .sharedPinOut, .sharedPinOe, .portDOut, .cmpOneOut, .cmpTwoOut, .halted,
    .wakeRequest, .s_axi_araddr, .s_axi_rdata, .s_axi_rvalid);

/* testbench/pceo_pin_model.sv */
// Outside pins and comparator outputs facing the shared port
`timescale 1ns/1ns
module pceo_pin_model (
    input wire logic [3:0] sharedPinOut,
    input wire logic [3:0] sharedPinOe,
    input wire logic [3:0] extLevel,
    input wire logic [1:0] cmpLevel,
    output logic [3:0] sharedPinIn,
    output logic cmpOneOut,
    output logic cmpTwoOut
);
    assign sharedPinIn = (sharedPinOe & sharedPinOut) | (~sharedPinOe & extLevel);
    assign cmpOneOut = cmpLevel[0];
    assign cmpTwoOut = cmpLevel[1];
endmodule // pceo_pin_model

/* testbench/test_port_ce_option_read_mux.sv */
// Random and corner option sets checked over the register bus and pins
`timescale 1ns/1ns
`include "pceo_params.svh"
module test_port_ce_option_read_mux;
    logic core_clk = 1'b0, resetn = 1'b0, halted = 1'b0, cmpOneOut, cmpTwoOut, gainAllowed;
    logic wakeRequest, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, cmpLevel = 2'h0;
    logic [3:0] extLevel = 4'h0, s_axi_wstrb = 4'hF;
    logic [3:0] sharedPinIn, sharedPinOut, sharedPinOe, portDOut;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] optionStrap = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
    int mismatches = 0, testsRun = 0, cycles = 0;
    localparam logic [31:0] CORNER [6] = '{32'hF80, 32'h82, 32'hD2, 32'h45, 32'h4D, 32'h5A000};
    always #20 core_clk = ~core_clk;
    pceo_port DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .optionStrap(optionStrap),
        .sharedPinIn(sharedPinIn),
        .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe),
        .portDOut(portDOut),
        .cmpOneOut(cmpOneOut),
        .cmpTwoOut(cmpTwoOut),
        .halted(halted),
        .wakeRequest(wakeRequest),
        .gainAllowed(gainAllowed),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    pceo_pin_model pins (.sharedPinOut, .sharedPinOe, .extLevel, .cmpLevel, .sharedPinIn,
        .cmpOneOut, .cmpTwoOut);
    task automatic chk(input string n, input logic [3:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic axw(input logic [11:0] a, input logic [3:0] v);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {28'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [3:0] v, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata[3:0];
        r = s_axi_rresp;
    endtask
    // Driven pins read back data or forced level, others the outside level
    function automatic logic [3:0] expRd(logic [31:0] s, logic [3:0] d, dir, x, logic [1:0] c);
        logic [3:0] e;
        e = s[7] ? (dir & (d | s[15:12])) | (~dir & x) : x;
        if (!s[6] && !s[7]) return d;
        if (s[0]) e[1:0] = {e[1] & !s[3], c[0]};
        // Comparator two view needs the amplifier off
        if (s[1] && !s[2]) e[3:2] = {e[3] & !s[4], c[1]};
        if (s[0] && s[2]) e[3:2] = 2'h0;
        return e;
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        logic [31:0] s;
        logic [3:0] d, dir, v, oe, e;
        logic [1:0] r;
        logic w;
        int i;
        void'($urandom(32'hEF273CFD));
        for (int k = 0; k < 24; k++) begin
            s = k < 6 ? CORNER[k] : $urandom;
            s[1] = s[1] && !(s[0] && s[2]);
            s[5] = s[5] && !s[2];
            resetn <= 1'b0;
            halted <= 1'b0;
            optionStrap <= s;
            d = 4'($urandom);
            dir = 4'($urandom);
            extLevel <= 4'($urandom);
            cmpLevel <= 2'($urandom);
            repeat (6) @(posedge core_clk);
            resetn <= 1'b1;
            axw(`PCEO_ADDR_DATA, d);
            axw(`PCEO_ADDR_DIR, dir);
            // Even passes write port D with byte lane zero off, which must store nothing
            s_axi_wstrb <= {4{k[0]}};
            axw(`PCEO_ADDR_PORTD, ~d);
            s_axi_wstrb <= 4'hF;
            axr(`PCEO_ADDR_DATA, v, r);
            e = expRd(s, d, dir, extLevel, cmpLevel);
            chk("data", v, e);
            axr(12'hFFC, v, r);
            chk("unmapped", {2'h0, r}, {2'h0, `PCEO_SLVERR});
            axr(`PCEO_ADDR_OPTION, v, r);
            chk("option", v, s[3:0]);
            chk("gain", {3'h0, gainAllowed}, {3'h0, s[5]});
            oe = s[7] ? dir : {4{!s[6]}};
            chk("enable", sharedPinOe, oe);
            chk("drive", sharedPinOut, d | s[15:12]);
            chk("port D", portDOut, (k[0] ? ~d : `PCEO_RST_PORTD) | s[19:16]);
            i = $urandom_range(3);
            halted <= 1'b1;
            extLevel <= 4'h0;
            repeat (4) @(posedge core_clk);
            extLevel[i] <= 1'b1;
            w = 1'b0;
            repeat (8) begin
                @(posedge core_clk);
                w = w | wakeRequest;
            end
            chk("wake", {3'h0, w}, {3'h0, s[8 + i] && !oe[i]});
            $display("test %0d options %h done", k, s);
        end
        results();
    end
endmodule // test_port_ce_option_read_mux
